// ===== core/serial_bus_status_flags.sv
// status flags and data line steering of the two-wire serial interface
`timescale 1ns/100ps
module serial_bus_status_flags
  import sbs_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_serial_bus_control,
  input wire logic i_ctl_wr,
  input wire logic i_master_mode,
  input wire logic i_master_start,
  input wire logic i_so_latch,
  input wire logic i_rd,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_sda_out,
  output logic o_sda_oe
);
  generate
    if (ADDR_W < 16)
    begin : g_bad_addr_w
      $error("ADDR_W too narrow for the status address");
    end
  endgenerate

  bus_events_if ev ();

  line_sync u_line_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ev(ev.sync)
  );

  bit_counter u_bit_counter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .ev(ev.count)
  );

  logic send_direction_flag;
  logic ack_detected_flag;
  logic start_seen_flag;
  logic stop_seen_flag;
  logic drive_en;
  logic enable_d;

  // ==========================================================================
  // control bits and derived events
  logic iface_enable;
  logic bus_release_ctl;
  logic wait_release_ctl;
  logic enable_fall;
  logic lsb_rise_b0;
  logic ack_rise;
  logic ack_fall_b0;
  logic next_byte_rise;
  logic addr_first_rise;
  logic in_ack_clock;
  logic wait_rel_hit;
  logic trc_set;
  logic trc_clr;

  assign iface_enable = i_serial_bus_control[CTL_ENABLE_BIT];
  assign bus_release_ctl = i_serial_bus_control[CTL_RELEASE_BIT];
  assign wait_release_ctl = i_ctl_wr & i_serial_bus_control[CTL_WAIT_REL_BIT];
  assign enable_fall = enable_d & ~iface_enable;
  assign lsb_rise_b0 = ev.scl_rise & ev.in_frame & ev.first_byte
    & (ev.bit_cnt == CNT_BEFORE_LSB);
  assign ack_rise = ev.scl_rise & ev.in_frame & (ev.bit_cnt == CNT_BEFORE_ACK);
  assign in_ack_clock = ev.in_frame & (ev.bit_cnt == CNT_ACK);
  assign ack_fall_b0 = ev.scl_fall & in_ack_clock & ev.first_byte;
  assign next_byte_rise = ev.scl_rise & in_ack_clock;
  assign addr_first_rise = ev.scl_rise & ev.in_frame & (ev.bit_cnt == CNT_IDLE);
  assign wait_rel_hit = wait_release_ctl & send_direction_flag & in_ack_clock;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      enable_d <= 1'b0;
    end
    else
    begin
      enable_d <= iface_enable;
    end
  end

  // ==========================================================================
  // send direction flag; a set wins over any clear in the same cycle
  assign trc_set = (i_master_mode & i_master_start)
    | (~i_master_mode & lsb_rise_b0 & ev.sda);
  assign trc_clr = (i_master_mode & lsb_rise_b0 & i_so_latch)
    | wait_rel_hit
    | bus_release_ctl | enable_fall;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      send_direction_flag <= 1'b0;
    end
    else if (trc_set)
    begin
      send_direction_flag <= 1'b1;
    end
    else if (trc_clr)
    begin
      send_direction_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // data line steering: a slave starts driving after the first byte's ack clock
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      drive_en <= 1'b0;
    end
    else if (ev.start_det || ev.stop_det || bus_release_ctl || wait_rel_hit || enable_fall)
    begin
      drive_en <= 1'b0;
    end
    else if (ack_fall_b0)
    begin
      drive_en <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_sda_out <= 1'b1;
    end
    else
    begin
      o_sda_out <= i_so_latch;
    end
  end

  // line floats whenever the send flag is clear
  assign o_sda_oe = send_direction_flag & (i_master_mode | drive_en);

  // ==========================================================================
  // acknowledge detected flag
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ack_detected_flag <= 1'b0;
    end
    else if (ack_rise && !ev.sda)
    begin
      ack_detected_flag <= 1'b1;
    end
    else if (ev.stop_det || next_byte_rise || bus_release_ctl || enable_fall)
    begin
      ack_detected_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // start seen flag
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      start_seen_flag <= 1'b0;
    end
    else if (ev.start_det)
    begin
      start_seen_flag <= 1'b1;
    end
    else if (ev.stop_det || (next_byte_rise && ev.first_byte) || bus_release_ctl
      || enable_fall)
    begin
      start_seen_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // stop seen flag
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      stop_seen_flag <= 1'b0;
    end
    else if (ev.stop_det)
    begin
      stop_seen_flag <= 1'b1;
    end
    else if (addr_first_rise || enable_fall)
    begin
      stop_seen_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // status register read port
  logic [7:0] status_word;

  always_comb
  begin
    status_word = STATUS_RESET;
    status_word[TRC_BIT] = send_direction_flag;
    status_word[ACK_BIT] = ack_detected_flag;
    status_word[STD_BIT] = start_seen_flag;
    status_word[SPD_BIT] = stop_seen_flag;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rd_data <= STATUS_RESET;
    end
    else if (i_rd && (i_rd_addr[15:0] == STATUS_ADDR))
    begin
      o_rd_data <= status_word;
    end
    else
    begin
      o_rd_data <= STATUS_RESET;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence first_byte_done_s;
    ack_fall_b0 && send_direction_flag && !trc_clr;
  endsequence

  sequence quiet_s;
    !ev.start_det && !ev.stop_det && !bus_release_ctl && !wait_rel_hit;
  endsequence

  recv_line_hiz_a: assert property (!send_direction_flag |-> !o_sda_oe)
    else $error("data line driven while receiving");
  send_line_drive_a: assert property (first_byte_done_s and quiet_s |=> o_sda_oe)
    else $error("data line not driven after first byte");
  drive_value_a: assert property (o_sda_oe |-> o_sda_out == $past(i_so_latch))
    else $error("driven value is not the output latch");
  trc_set_a: assert property (trc_set |=> send_direction_flag)
    else $error("send flag not set");
  trc_master_clr_a: assert property
    (i_master_mode && lsb_rise_b0 && i_so_latch && !trc_set |=> !send_direction_flag)
    else $error("send flag not cleared after read bit");
  wait_release_a: assert property
    (wait_rel_hit && !trc_set |=> !send_direction_flag && !o_sda_oe)
    else $error("wait release did not free the line");
  ack_set_a: assert property (ack_rise && !ev.sda |=> ack_detected_flag)
    else $error("acknowledge not flagged");
  ack_clear_a: assert property
    ((ev.stop_det || enable_fall) && !ack_rise |=> !ack_detected_flag)
    else $error("acknowledge flag not cleared");
  start_set_a: assert property (ev.start_det |=> start_seen_flag)
    else $error("start flag not set");
  start_clear_a: assert property
    (next_byte_rise && ev.first_byte && !ev.start_det |=> !start_seen_flag)
    else $error("start flag not cleared after address");
  stop_set_a: assert property (ev.stop_det |=> stop_seen_flag)
    else $error("stop flag not set");
  stop_clear_a: assert property (addr_first_rise && !ev.stop_det |=> !stop_seen_flag)
    else $error("stop flag not cleared on new address");
  status_layout_a: assert property
    (i_rd && i_rd_addr[15:0] == STATUS_ADDR |=> o_rd_data == {4'h0,
    $past(send_direction_flag), $past(ack_detected_flag), $past(start_seen_flag),
    $past(stop_seen_flag)})
    else $error("status word layout wrong");
  enable_fall_a: assert property
    (($fell(iface_enable) && !ack_rise) and quiet_s |=> !stop_seen_flag && !ack_detected_flag)
    else $error("flags survive enable fall");
endmodule : serial_bus_status_flags

// ===== core/sbs_pkg.sv
// constants shared by the serial bus status flag block
package sbs_pkg;
  // ==========================================================================
  // status register
  localparam logic [15:0] STATUS_ADDR = 16'hff79;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int TRC_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int STD_BIT = 1;
  localparam int SPD_BIT = 0;
  // ==========================================================================
  // control register bits
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_RELEASE_BIT = 6;
  localparam int CTL_WAIT_REL_BIT = 5;
  // ==========================================================================
  // serial clock counting within a byte (count of rising edges seen)
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_IDLE = 4'h0;
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_BEFORE_LSB = 4'h7;
  localparam logic [3:0] CNT_BEFORE_ACK = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;
endpackage : sbs_pkg

// ===== core/bus_events_if.sv
// carrier of synchronised line levels, bus events and bit position
`timescale 1ns/100ps
interface bus_events_if;
  import sbs_pkg::*;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [CNT_W-1:0] bit_cnt;
  logic first_byte;
  logic in_frame;
  modport sync (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport count (input scl_rise, start_det, stop_det, output bit_cnt, first_byte, in_frame);
  modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det, bit_cnt, first_byte,
    in_frame);
endinterface : bus_events_if

// ===== core/line_sync.sv
// pin synchronisers, line edge finding and start/stop detection
`timescale 1ns/100ps
module line_sync
  import sbs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  bus_events_if.sync ev
);
  logic scl_meta;
  logic sda_meta;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;

  // ==========================================================================
  // two-stage synchronisers, then one delay stage for edges
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_meta <= i_scl;
      sda_meta <= i_sda;
      scl_s <= scl_meta;
      sda_s <= sda_meta;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign ev.scl = scl_s;
  assign ev.sda = sda_s;
  assign ev.scl_rise = scl_s & ~scl_d;
  assign ev.scl_fall = ~scl_s & scl_d;
  // data moves while clock stays high
  assign ev.start_det = sda_d & ~sda_s & scl_s & scl_d;
  assign ev.stop_det = ~sda_d & sda_s & scl_s & scl_d;
endmodule : line_sync

// ===== core/bit_counter.sv
// counts serial clock rising edges within each byte of a frame
`timescale 1ns/100ps
module bit_counter
  import sbs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  bus_events_if.count ev
);
  logic [CNT_W-1:0] cnt;
  logic first;
  logic frame;

  // ==========================================================================
  // position in the byte; start restarts, stop ends the frame
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt <= CNT_IDLE;
      first <= 1'b1;
      frame <= 1'b0;
    end
    else if (ev.start_det)
    begin
      cnt <= CNT_IDLE;
      first <= 1'b1;
      frame <= 1'b1;
    end
    else if (ev.stop_det)
    begin
      cnt <= CNT_IDLE;
      first <= 1'b1;
      frame <= 1'b0;
    end
    else if (ev.scl_rise && frame)
    begin
      if (cnt == CNT_ACK)
      begin
        cnt <= CNT_FIRST;
        first <= 1'b0;
      end
      else
      begin
        cnt <= cnt + CNT_FIRST;
      end
    end
  end

  assign ev.bit_cnt = cnt;
  assign ev.first_byte = first;
  assign ev.in_frame = frame;
endmodule : bit_counter

// ===== bench/bus_peer.sv
// bus peer model: makes the serial clock and pulls the data line low
`timescale 1ns/100ps
module bus_peer
(
  output logic o_scl,
  output logic o_sda_low
);
  // ==========================================================================
  // idle bus: both lines released to their pull-ups
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // ==========================================================================
  // bus conditions, 64 ns serial clock period, clock stands high outside frames
  task automatic start_cond();
    o_sda_low = 1'b0;
    #16;
    o_scl = 1'b1;
    #16;
    o_sda_low = 1'b1;
    #16;
    o_scl = 1'b0;
    #16;
  endtask : start_cond

  // data changes only while the clock is low; a 1 releases the line
  // the line is let go once the clock is low again
  task automatic put_bit(input logic b);
    o_sda_low = ~b;
    #16;
    o_scl = 1'b1;
    #32;
    o_scl = 1'b0;
    #8;
    o_sda_low = 1'b0;
    #8;
  endtask : put_bit

  task automatic stop_cond();
    o_sda_low = 1'b1;
    #16;
    o_scl = 1'b1;
    #16;
    o_sda_low = 1'b0;
    #32;
  endtask : stop_cond
endmodule : bus_peer

// ===== bench/serial_bus_status_flags_bench.sv
// self-checking bench of the serial bus status flags
`timescale 1ns/100ps
module serial_bus_status_flags_bench;
  import sbs_pkg::*;
  logic i_clk;
  logic i_srst;
  logic [7:0] ctl;
  logic ctl_wr;
  logic master_mode;
  logic master_start;
  logic so_latch;
  logic rd;
  logic [15:0] rd_addr;
  logic [7:0] rd_data;
  logic sda_out;
  logic sda_oe;
  logic scl;
  logic sda_low;
  wire sda_line;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  // ==========================================================================
  // wired-and data line with pull-up
  assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);

  serial_bus_status_flags uut (.i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_line),
    .i_serial_bus_control(ctl), .i_ctl_wr(ctl_wr), .i_master_mode(master_mode),
    .i_master_start(master_start), .i_so_latch(so_latch), .i_rd(rd), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_sda_out(sda_out), .o_sda_oe(sda_oe));
  bus_peer peer (.o_scl(scl), .o_sda_low(sda_low));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      $display("mismatch at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // ==========================================================================
  // shared checks
  function automatic logic [7:0] st(input logic t, input logic a, input logic s,
    input logic p);
    st = 8'h00;
    st[TRC_BIT] = t;
    st[ACK_BIT] = a;
    st[STD_BIT] = s;
    st[SPD_BIT] = p;
  endfunction : st

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // waits for the synchronisers, then one read strobe; data shows the next cycle
  task automatic read_at(input logic [15:0] addr, input logic [7:0] exp, input string what);
    repeat (6) @(negedge i_clk);
    rd = 1'b1;
    rd_addr = addr;
    @(negedge i_clk);
    rd = 1'b0;
    check(rd_data, exp, what);
  endtask : read_at

  task automatic set_ctl(input logic [7:0] v);
    @(negedge i_clk);
    ctl = v;
  endtask : set_ctl

  task automatic bits(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
      peer.put_bit(d[7-i]);
  endtask : bits

  // ==========================================================================
  // scenarios
  task automatic test_reset();
    read_at(STATUS_ADDR, STATUS_RESET, "reset status");
    read_at(16'hff7a, 8'h00, "unmapped read");
    check({7'h00, sda_oe}, 8'h00, "idle drive");
    $display("test reset done");
  endtask : test_reset

  task automatic test_slave();
    set_ctl(8'h80);
    peer.start_cond();
    read_at(STATUS_ADDR, st(0, 0, 1, 0), "start seen");
    bits(8'ha5, 8);
    read_at(STATUS_ADDR, st(1, 0, 1, 0), "slave send set");
    check({7'h00, sda_oe}, 8'h00, "no drive before 9th fall");
    peer.put_bit(1'b0);
    read_at(STATUS_ADDR, st(1, 1, 1, 0), "ack seen");
    check({6'h00, sda_oe, sda_line}, 8'h02, "drives latch low");
    so_latch = 1'b1;
    repeat (3) @(negedge i_clk);
    check({6'h00, sda_out, sda_line}, 8'h03, "drives latch high");
    peer.put_bit(1'b1);
    read_at(STATUS_ADDR, st(1, 0, 0, 0), "next byte first rise");
    bits(8'hff, 7);
    peer.put_bit(1'b0);
    read_at(STATUS_ADDR, st(1, 1, 0, 0), "second ack");
    @(negedge i_clk);
    ctl = 8'ha0;
    ctl_wr = 1'b1;
    @(negedge i_clk);
    ctl = 8'h80;
    ctl_wr = 1'b0;
    read_at(STATUS_ADDR, st(0, 1, 0, 0), "wait release");
    check({7'h00, sda_oe}, 8'h00, "line freed");
    peer.stop_cond();
    read_at(STATUS_ADDR, st(0, 0, 0, 1), "stop seen");
    peer.start_cond();
    read_at(STATUS_ADDR, st(0, 0, 1, 1), "stop kept over start");
    set_ctl(8'hc0);
    read_at(STATUS_ADDR, st(0, 0, 0, 1), "release clears start");
    set_ctl(8'h80);
    peer.stop_cond();
    $display("test slave done");
  endtask : test_slave

  task automatic test_master();
    logic [7:0] addr_byte;
    addr_byte = 8'ha5;
    @(negedge i_clk);
    master_mode = 1'b1;
    master_start = 1'b1;
    @(negedge i_clk);
    master_start = 1'b0;
    read_at(STATUS_ADDR, st(1, 0, 0, 1), "master start");
    check({7'h00, sda_oe}, 8'h01, "master drives");
    peer.start_cond();
    for (int i = 0; i < 8; i++)
    begin
      @(negedge i_clk);
      so_latch = addr_byte[7-i];
      peer.put_bit(1'b1);
    end
    read_at(STATUS_ADDR, st(0, 0, 1, 0), "master receive");
    check({7'h00, sda_oe}, 8'h00, "master line freed");
    peer.put_bit(1'b0);
    read_at(STATUS_ADDR, st(0, 1, 1, 0), "master ack");
    set_ctl(8'h00);
    read_at(STATUS_ADDR, st(0, 0, 0, 0), "enable fall");
    set_ctl(8'h80);
    peer.stop_cond();
    read_at(STATUS_ADDR, st(0, 0, 0, 1), "stop again");
    set_ctl(8'h00);
    read_at(STATUS_ADDR, st(0, 0, 0, 0), "enable fall stop");
    master_mode = 1'b0;
    $display("test master done");
  endtask : test_master

  // ==========================================================================
  // closing report
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    i_srst = 1'b1;
    ctl = 8'h00;
    ctl_wr = 1'b0;
    master_mode = 1'b0;
    master_start = 1'b0;
    so_latch = 1'b0;
    rd = 1'b0;
    rd_addr = 16'h0000;
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    test_reset();
    test_slave();
    test_master();
    complete_run();
  end
endmodule : serial_bus_status_flags_bench
